// *** rtl/rcic_map.svh ***
// Register offsets, field positions, reset values and counts of the input conditioner.
// Assumes a word-addressed plain register port with 16-bit data.
`ifndef RCIC_MAP_SVH
`define RCIC_MAP_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define RCIC_NUM_INPUTS 16
`define RCIC_NUM_LOCKOUTS 8
`define RCIC_ADDR_W 5
`define RCIC_DATA_W 16
`define RCIC_CFG_W 11

// ****************************************************************
// Register offsets
// ****************************************************************
`define RCIC_ADDR_CFG0 5'h00
`define RCIC_ADDR_CTRL 5'h10
`define RCIC_ADDR_LEVEL 5'h11
`define RCIC_ADDR_STATUS 5'h12
`define RCIC_ADDR_SETTINGS 5'h13

// ****************************************************************
// Field positions
// ****************************************************************
`define RCIC_FN_LSB 0
`define RCIC_FN_MSB 3
`define RCIC_MODE_LSB 4
`define RCIC_MODE_MSB 7
`define RCIC_IDX_LSB 8
`define RCIC_IDX_MSB 10
`define RCIC_CTRL_APPLY_BIT 0
`define RCIC_CTRL_CANCEL_BIT 1
`define RCIC_SET_STANDBY_BIT 0
`define RCIC_ST_REMOTE_BIT 0
`define RCIC_ST_RF_BIT 1
`define RCIC_ST_EXC_B_BIT 2
`define RCIC_ST_AUTO_BIT 3
`define RCIC_ST_SCHED_BIT 4
`define RCIC_ST_LOCK_LSB 8

// ****************************************************************
// Reset values
// ****************************************************************
`define RCIC_CFG_RST 11'h000
`define RCIC_STANDBY_RST 1'b1

`endif

// *** rtl/rcic_pkg.sv ***
// Types shared by the input conditioner modules.
// Assumes nothing beyond a SystemVerilog compiler.
package rcic_pkg;

  // ****************************************************************
  // Function assigned to an input
  // ****************************************************************
  typedef enum logic [3:0] {
    FN_NONE = 4'h0,
    FN_RF = 4'h1,
    FN_RESET = 4'h2,
    FN_POWER_STEP = 4'h3,
    FN_MAIN_EXC = 4'h4,
    FN_AUTO_CO = 4'h5,
    FN_SCHED = 4'h6,
    FN_LOCKOUT = 4'h7,
    FN_PRESET = 4'h8
  } func_t;

  // ****************************************************************
  // Trigger mode of an input
  // ****************************************************************
  typedef enum logic [3:0] {
    MD_RISE_ON = 4'h0,
    MD_FALL_ON = 4'h1,
    MD_RISE_OFF = 4'h2,
    MD_FALL_OFF = 4'h3,
    MD_FALL_TOG = 4'h4,
    MD_RISE_TOG = 4'h5,
    MD_RISE_FOLLOW = 4'h6,
    MD_FALL_FOLLOW = 4'h7,
    MD_HIGH_INC = 4'h8,
    MD_LOW_INC = 4'h9,
    MD_HIGH_DEC = 4'hA,
    MD_LOW_DEC = 4'hB,
    MD_HIGH_ON = 4'hC,
    MD_LOW_ON = 4'hD
  } mode_t;

endpackage : rcic_pkg

// *** rtl/input_sync.sv ***
// Two-stage synchroniser with a third stage that keeps the previous sample.
// Assumes the input may change at any time relative to the clock.
module input_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic level,
  output logic level_prev
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // ****************************************************************
  // Synchroniser and history
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= din; // [R20]
      sync_ff <= meta_ff; // [R20]
      prev_ff <= sync_ff; // [R20]
    end
  end

  assign level = sync_ff;
  assign level_prev = prev_ff;

endmodule : input_sync

// *** rtl/channel_trigger.sv ***
// Trigger-mode decoder for one remote input channel.
// Assumes synchronised current and previous samples of the input.
module channel_trigger
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cur,
  input wire logic prev,
  input wire rcic_pkg::mode_t mode,
  output logic on_pulse,
  output logic off_pulse,
  output logic hold_inc,
  output logic hold_dec
);

  logic tog_ff;
  logic nxt_tog;
  logic rise;
  logic fall;
  logic m_rise_on, m_fall_on, m_rise_off, m_fall_off, m_fall_tog, m_rise_tog;
  logic m_rise_fol, m_fall_fol, m_hi_inc, m_lo_inc, m_hi_dec, m_lo_dec, m_hi_on, m_lo_on;

  // ****************************************************************
  // Edge detection and mode decode
  // ****************************************************************
  assign rise = cur & ~prev; // [R20]
  assign fall = ~cur & prev; // [R20]
  assign m_rise_on = (mode == rcic_pkg::MD_RISE_ON);
  assign m_fall_on = (mode == rcic_pkg::MD_FALL_ON);
  assign m_rise_off = (mode == rcic_pkg::MD_RISE_OFF);
  assign m_fall_off = (mode == rcic_pkg::MD_FALL_OFF);
  assign m_fall_tog = (mode == rcic_pkg::MD_FALL_TOG);
  assign m_rise_tog = (mode == rcic_pkg::MD_RISE_TOG);
  assign m_rise_fol = (mode == rcic_pkg::MD_RISE_FOLLOW);
  assign m_fall_fol = (mode == rcic_pkg::MD_FALL_FOLLOW);
  assign m_hi_inc = (mode == rcic_pkg::MD_HIGH_INC);
  assign m_lo_inc = (mode == rcic_pkg::MD_LOW_INC);
  assign m_hi_dec = (mode == rcic_pkg::MD_HIGH_DEC);
  assign m_lo_dec = (mode == rcic_pkg::MD_LOW_DEC);
  assign m_hi_on = (mode == rcic_pkg::MD_HIGH_ON);
  assign m_lo_on = (mode == rcic_pkg::MD_LOW_ON);

  // ****************************************************************
  // Activate and deactivate events, and held increase and decrease requests
  // ****************************************************************
  assign on_pulse = (m_rise_on & rise) | (m_fall_on & fall) // [R11]
                  | (m_rise_tog & rise & ~tog_ff) | (m_fall_tog & fall & tog_ff) // [R13]
                  | (m_rise_fol & rise) | (m_fall_fol & fall) // [R14]
                  | (m_hi_inc & rise) // [R15]
                  | (m_hi_on & rise) | (m_lo_on & fall); // [R17]
  assign off_pulse = (m_rise_off & rise) | (m_fall_off & fall) // [R12]
                   | (m_rise_tog & rise & tog_ff) | (m_fall_tog & fall & ~tog_ff) // [R13]
                   | (m_rise_fol & fall) | (m_fall_fol & rise) // [R14]
                   | (m_hi_on & fall) | (m_lo_on & rise); // [R17]
  assign hold_inc = (m_hi_inc & cur) | (m_lo_inc & ~cur); // [R15]
  assign hold_dec = (m_hi_dec & cur) | (m_lo_dec & ~cur); // [R16]

  // ****************************************************************
  // Toggle parity
  // ****************************************************************
  assign nxt_tog = tog_ff ^ ((m_rise_tog & rise) | (m_fall_tog & fall)); // [R13]

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tog_ff <= 1'b0;
    end
    else
    begin
      tog_ff <= nxt_tog;
    end
  end

endmodule : channel_trigger

// *** rtl/remote_control_input_conditioner.sv ***
// Remote digital input conditioner: sixteen inputs, each mapped to a control function.
// Assumes REF_CLK at 200 MHz, synchronous RST and a plain word-addressed register port.
//
// Functional notes
// R01: Sixteen inputs, each configured on its own.
// R02: Remote requests ignored unless control state remote.
// R03: Only the console may select remote control.
// R04: Selector picks one of nine functions.
// R05: Unassigned input never produces any request.
// R06: Lockout input sets lockout one-eight in either state.
// R07: RF input acts like console RF buttons.
// R08: Reset input issues system reset on trigger.
// R09: Power step input requests increase or decrease.
// R10: Present input levels readable by software.
// R11: Edge activate modes activate on chosen polarity.
// R12: Edge deactivate modes deactivate on chosen polarity.
// R13: Toggle modes alternate state on each edge.
// R14: Follow modes activate one level, deactivate other.
// R15: Active increase modes request increase while active.
// R16: Active decrease modes request decrease while active.
// R17: Active turn-on modes activate while level held.
// R18: Configuration takes effect on apply; cancel restores.
// R19: Changeover requests refused without standby exciter.
// R20: Inputs double-synchronised; edges from consecutive samples.
//
// The placing of the registers and strobed register access were decided locally.
`include "rcic_map.svh"

module remote_control_input_conditioner
#(
  parameter int NUM_INPUTS = `RCIC_NUM_INPUTS,
  parameter int NUM_LOCKOUTS = `RCIC_NUM_LOCKOUTS
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [NUM_INPUTS-1:0] REMOTE_IN,
  input wire logic CONSOLE_SET_REMOTE,
  input wire logic CONSOLE_SET_LOCAL,
  input wire logic CONSOLE_RF_ON,
  input wire logic CONSOLE_RF_OFF,
  input wire logic [`RCIC_ADDR_W-1:0] ADDR,
  input wire logic [`RCIC_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [`RCIC_DATA_W-1:0] RDATA,
  output logic REMOTE_MODE,
  output logic RF_ON,
  output logic RF_ON_REQ,
  output logic RF_OFF_REQ,
  output logic SYS_RESET_REQ,
  output logic POWER_INC_REQ,
  output logic POWER_DEC_REQ,
  output logic MAIN_EXCITER_B,
  output logic AUTO_CHANGEOVER,
  output logic SCHEDULER_ON,
  output logic [NUM_LOCKOUTS-1:0] LOCKOUT_ACTIVE,
  output logic PRESET_REQ,
  output logic [2:0] PRESET_IDX
);

  localparam int CW = `RCIC_CFG_W;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [CW-1:0] cfg_pend_ff [NUM_INPUTS];
  logic [CW-1:0] cfg_act_ff [NUM_INPUTS];
  logic remote_ff;
  logic standby_ff;
  logic rf_on_ff;
  logic exc_b_ff;
  logic auto_co_ff;
  logic sched_ff;
  logic [NUM_LOCKOUTS-1:0] lockout_ff;
  logic rf_on_req_ff;
  logic rf_off_req_ff;
  logic reset_req_ff;
  logic inc_ff;
  logic dec_ff;
  logic preset_req_ff;
  logic [2:0] preset_idx_ff;
  logic [`RCIC_DATA_W-1:0] rdata_ff;
  logic [NUM_INPUTS-1:0] lvl;
  logic [NUM_INPUTS-1:0] prv;
  logic [NUM_INPUTS-1:0] on_raw, off_raw, inc_raw, dec_raw;
  logic [NUM_INPUTS-1:0] gate, on_g, off_g, inc_g, dec_g;
  logic [NUM_INPUTS-1:0] is_rf, is_rst, is_pwr, is_exc, is_auto, is_sched, is_lock, is_pre;
  logic [2:0] idx [NUM_INPUTS];
  logic [NUM_INPUTS-1:0] lk_on_m [NUM_LOCKOUTS];
  logic [NUM_INPUTS-1:0] lk_off_m [NUM_LOCKOUTS];
  logic [NUM_LOCKOUTS-1:0] lk_set, lk_clr;
  logic wr_ctrl, wr_set, apply, cancel;
  logic rf_set, rf_clr, auto_set, auto_clr;
  logic pre_hit;
  logic [2:0] pre_idx;
  logic [`RCIC_DATA_W-1:0] cfg_rd;
  logic [`RCIC_DATA_W-1:0] status_rd;
  logic [`RCIC_DATA_W-1:0] rd_mux;

  // ****************************************************************
  // Per-channel conditioning and function decode
  // ****************************************************************
  for (genvar i = 0; i < NUM_INPUTS; i++)
  begin : g_ch
    rcic_pkg::func_t fn;
    rcic_pkg::mode_t md;

    assign fn = rcic_pkg::func_t'(cfg_act_ff[i][`RCIC_FN_MSB:`RCIC_FN_LSB]); // [R01]
    assign md = rcic_pkg::mode_t'(cfg_act_ff[i][`RCIC_MODE_MSB:`RCIC_MODE_LSB]); // [R01]
    assign idx[i] = cfg_act_ff[i][`RCIC_IDX_MSB:`RCIC_IDX_LSB];

    input_sync u_sync
    (
      .clk(REF_CLK),
      .rst(RST),
      .din(REMOTE_IN[i]),
      .level(lvl[i]),
      .level_prev(prv[i])
    );

    channel_trigger u_trig
    (
      .clk(REF_CLK),
      .rst(RST),
      .cur(lvl[i]),
      .prev(prv[i]),
      .mode(md),
      .on_pulse(on_raw[i]),
      .off_pulse(off_raw[i]),
      .hold_inc(inc_raw[i]),
      .hold_dec(dec_raw[i])
    );

    assign is_rf[i] = (fn == rcic_pkg::FN_RF); // [R04]
    assign is_rst[i] = (fn == rcic_pkg::FN_RESET); // [R04]
    assign is_pwr[i] = (fn == rcic_pkg::FN_POWER_STEP); // [R04]
    assign is_exc[i] = (fn == rcic_pkg::FN_MAIN_EXC); // [R04]
    assign is_auto[i] = (fn == rcic_pkg::FN_AUTO_CO); // [R04]
    assign is_sched[i] = (fn == rcic_pkg::FN_SCHED); // [R04]
    assign is_lock[i] = (fn == rcic_pkg::FN_LOCKOUT); // [R04]
    assign is_pre[i] = (fn == rcic_pkg::FN_PRESET); // [R04]

    // Unassigned and unknown codes match no function and so drive nothing.
    assign gate[i] = remote_ff | is_lock[i]; // [R02] [R06] [R05]
    assign on_g[i] = on_raw[i] & gate[i]; // [R02]
    assign off_g[i] = off_raw[i] & gate[i]; // [R02]
    assign inc_g[i] = inc_raw[i] & gate[i]; // [R02]
    assign dec_g[i] = dec_raw[i] & gate[i]; // [R02]

    for (genvar k = 0; k < NUM_LOCKOUTS; k++)
    begin : g_lk
      assign lk_on_m[k][i] = on_g[i] & is_lock[i] & (idx[i] == 3'(k)); // [R06]
      assign lk_off_m[k][i] = off_g[i] & is_lock[i] & (idx[i] == 3'(k)); // [R06]
    end
  end

  for (genvar k = 0; k < NUM_LOCKOUTS; k++)
  begin : g_lock
    assign lk_set[k] = |lk_on_m[k];
    assign lk_clr[k] = |lk_off_m[k];
  end

  // ****************************************************************
  // Request combining
  // ****************************************************************
  assign rf_set = CONSOLE_RF_ON | (|(on_g & is_rf)); // [R07]
  assign rf_clr = CONSOLE_RF_OFF | (|(off_g & is_rf)); // [R07]
  assign auto_set = standby_ff & (|(on_g & is_auto)); // [R19]
  assign auto_clr = standby_ff & (|(off_g & is_auto)); // [R19]

  // Lowest numbered channel wins when several presets fire together.
  always_comb
  begin
    pre_hit = 1'b0;
    pre_idx = 3'h0;
    for (int i = NUM_INPUTS - 1; i >= 0; i--)
    begin
      if (on_g[i] && is_pre[i])
      begin
        pre_hit = 1'b1;
        pre_idx = idx[i];
      end
    end
  end

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  assign wr_ctrl = WR && (ADDR == `RCIC_ADDR_CTRL);
  assign wr_set = WR && (ADDR == `RCIC_ADDR_SETTINGS);
  assign apply = wr_ctrl && WDATA[`RCIC_CTRL_APPLY_BIT]; // [R18]
  assign cancel = wr_ctrl && WDATA[`RCIC_CTRL_CANCEL_BIT] && !apply; // [R18]
  assign cfg_rd = {{(`RCIC_DATA_W-CW){1'b0}}, cfg_pend_ff[ADDR[3:0]]};
  assign status_rd = {lockout_ff, 3'h0, sched_ff, auto_co_ff, exc_b_ff, rf_on_ff, remote_ff};
  assign rd_mux = (ADDR < `RCIC_ADDR_CTRL) ? cfg_rd :
                  (ADDR == `RCIC_ADDR_LEVEL) ? lvl : // [R10]
                  (ADDR == `RCIC_ADDR_STATUS) ? status_rd :
                  (ADDR == `RCIC_ADDR_SETTINGS) ? {15'h0000, standby_ff} :
                  16'h0000;

  // ****************************************************************
  // Configuration storage
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      if (RST)
      begin
        cfg_pend_ff[i] <= `RCIC_CFG_RST;
        cfg_act_ff[i] <= `RCIC_CFG_RST;
      end
      else
      begin
        if (apply)
        begin
          cfg_act_ff[i] <= cfg_pend_ff[i]; // [R18]
        end
        if (cancel)
        begin
          cfg_pend_ff[i] <= cfg_act_ff[i]; // [R18]
        end
        else if (WR && (ADDR == 5'(i)))
        begin
          cfg_pend_ff[i] <= WDATA[CW-1:0]; // [R01]
        end
      end
    end
  end

  // ****************************************************************
  // Control state
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      remote_ff <= 1'b0;
      standby_ff <= `RCIC_STANDBY_RST;
      rf_on_ff <= 1'b0;
      exc_b_ff <= 1'b0;
      auto_co_ff <= 1'b0;
      sched_ff <= 1'b0;
      lockout_ff <= '0;
    end
    else
    begin
      if (CONSOLE_SET_REMOTE)
      begin
        remote_ff <= 1'b1; // [R03]
      end
      else if (CONSOLE_SET_LOCAL)
      begin
        remote_ff <= 1'b0; // [R03]
      end
      if (wr_set)
      begin
        standby_ff <= WDATA[`RCIC_SET_STANDBY_BIT];
      end
      rf_on_ff <= rf_set | (rf_on_ff & ~rf_clr); // [R07]
      exc_b_ff <= (|(on_g & is_exc)) | (exc_b_ff & ~(|(off_g & is_exc))); // [R11] [R14]
      auto_co_ff <= auto_set | (auto_co_ff & ~auto_clr); // [R19]
      sched_ff <= (|(on_g & is_sched)) | (sched_ff & ~(|(off_g & is_sched)));
      lockout_ff <= lk_set | (lockout_ff & ~lk_clr); // [R06]
    end
  end

  // ****************************************************************
  // Request pulses, levels and read data
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rf_on_req_ff <= 1'b0;
      rf_off_req_ff <= 1'b0;
      reset_req_ff <= 1'b0;
      inc_ff <= 1'b0;
      dec_ff <= 1'b0;
      preset_req_ff <= 1'b0;
      preset_idx_ff <= 3'h0;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rf_on_req_ff <= rf_set; // [R07]
      rf_off_req_ff <= rf_clr & ~rf_set; // [R07]
      reset_req_ff <= |(on_g & is_rst); // [R08]
      inc_ff <= |((inc_g | on_g) & is_pwr); // [R09] [R15]
      dec_ff <= |((dec_g | off_g) & is_pwr); // [R09] [R16]
      preset_req_ff <= pre_hit;
      if (pre_hit)
      begin
        preset_idx_ff <= pre_idx;
      end
      rdata_ff <= RD ? rd_mux : 16'h0000;
    end
  end

  assign RDATA = rdata_ff;
  assign REMOTE_MODE = remote_ff;
  assign RF_ON = rf_on_ff;
  assign RF_ON_REQ = rf_on_req_ff;
  assign RF_OFF_REQ = rf_off_req_ff;
  assign SYS_RESET_REQ = reset_req_ff;
  assign POWER_INC_REQ = inc_ff;
  assign POWER_DEC_REQ = dec_ff;
  assign MAIN_EXCITER_B = exc_b_ff;
  assign AUTO_CHANGEOVER = auto_co_ff;
  assign SCHEDULER_ON = sched_ff;
  assign LOCKOUT_ACTIVE = lockout_ff;
  assign PRESET_REQ = preset_req_ff;
  assign PRESET_IDX = preset_idx_ff;

endmodule : remote_control_input_conditioner

// *** verification/remote_equipment.sv ***
// Model of the remote control equipment that drives the digital input lines.
// Assumes the bench commands one line change at a time; all lines start low.
module remote_equipment
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_ch,
  input wire logic cmd_level,
  output logic [15:0] lines
);
  timeunit 1ns;
  timeprecision 100ps;

  always_ff @(posedge clk)
  begin
    if (rst)
      lines <= 16'h0000;
    else if (cmd_valid)
      lines[cmd_ch] <= cmd_level;
  end
endmodule : remote_equipment

// *** verification/rcic_assertions.sv ***
// Checker for the remote input conditioner, bound to its top module.
// Assumes one clock REF_CLK and synchronous active-high RST.
module rcic_checker
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic CONSOLE_SET_REMOTE,
  input wire logic CONSOLE_SET_LOCAL,
  input wire logic REMOTE_MODE,
  input wire logic RF_ON,
  input wire logic RF_ON_REQ,
  input wire logic RF_OFF_REQ,
  input wire logic SYS_RESET_REQ,
  input wire logic POWER_INC_REQ,
  input wire logic POWER_DEC_REQ,
  input wire logic PRESET_REQ,
  input wire logic [2:0] PRESET_IDX
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("Read data not zero outside the read answer.");
  chk_rf_on_req: assert property (RF_ON_REQ |-> RF_ON)
    else $error("RF on request without RF stage on.");
  chk_rf_off_req: assert property (RF_OFF_REQ && !RF_ON_REQ |-> !RF_ON)
    else $error("RF off request left RF stage on.");
  chk_rf_rise_cause: assert property ($rose(RF_ON) |-> RF_ON_REQ)
    else $error("RF stage turned on without a request.");
  chk_local_quiet: assert property (
    (SYS_RESET_REQ || PRESET_REQ || POWER_INC_REQ || POWER_DEC_REQ)
    |-> (REMOTE_MODE || $past(REMOTE_MODE)))
    else $error("Remote request issued in local control.");
  chk_remote_cause: assert property ($rose(REMOTE_MODE) |-> $past(CONSOLE_SET_REMOTE))
    else $error("Remote control entered without console command.");
  chk_local_cause: assert property (
    $fell(REMOTE_MODE) |-> $past(CONSOLE_SET_LOCAL) && !$past(CONSOLE_SET_REMOTE))
    else $error("Local control entered without console command.");
  chk_reset_pulse: assert property (SYS_RESET_REQ |=> !SYS_RESET_REQ)
    else $error("System reset request longer than one cycle.");
  chk_preset_hold: assert property (!PRESET_REQ |-> $stable(PRESET_IDX))
    else $error("Preset number changed without a preset request.");
endmodule : rcic_checker

bind remote_control_input_conditioner rcic_checker u_chk (.REF_CLK(REF_CLK), .RST(RST),
  .RD(RD), .RDATA(RDATA), .CONSOLE_SET_REMOTE(CONSOLE_SET_REMOTE),
  .CONSOLE_SET_LOCAL(CONSOLE_SET_LOCAL), .REMOTE_MODE(REMOTE_MODE), .RF_ON(RF_ON),
  .RF_ON_REQ(RF_ON_REQ), .RF_OFF_REQ(RF_OFF_REQ), .SYS_RESET_REQ(SYS_RESET_REQ),
  .POWER_INC_REQ(POWER_INC_REQ), .POWER_DEC_REQ(POWER_DEC_REQ), .PRESET_REQ(PRESET_REQ),
  .PRESET_IDX(PRESET_IDX));

// *** verification/test_remote_control_input_conditioner.sv ***
// Self-checking testbench of the remote input conditioner.
// Assumes the far-side model and the bound checker are compiled before it.
module test_remote_control_input_conditioner;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic REF_CLK, RST, WR, RD, cmd_valid, cmd_level, lvl, s, par;
  logic [3:0] cons, cmd_ch;
  logic [4:0] ADDR;
  logic [15:0] WDATA, RDATA, lines;
  logic REMOTE_MODE, RF_ON, RF_ON_REQ, RF_OFF_REQ, SYS_RESET_REQ, POWER_INC_REQ;
  logic POWER_DEC_REQ, MAIN_EXCITER_B, AUTO_CHANGEOVER, SCHEDULER_ON, PRESET_REQ;
  logic [7:0] LOCKOUT_ACTIVE;
  logic [2:0] PRESET_IDX;
  int errors, tests_run, n_req, n_rst, snap;

  remote_equipment u_far (.clk(REF_CLK), .rst(RST), .cmd_valid(cmd_valid), .cmd_ch(cmd_ch),
    .cmd_level(cmd_level), .lines(lines));
  remote_control_input_conditioner DUT (.REF_CLK(REF_CLK), .RST(RST), .REMOTE_IN(lines),
    .CONSOLE_SET_REMOTE(cons[0]), .CONSOLE_SET_LOCAL(cons[1]), .CONSOLE_RF_ON(cons[2]),
    .CONSOLE_RF_OFF(cons[3]), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .REMOTE_MODE(REMOTE_MODE), .RF_ON(RF_ON), .RF_ON_REQ(RF_ON_REQ), .RF_OFF_REQ(RF_OFF_REQ),
    .SYS_RESET_REQ(SYS_RESET_REQ), .POWER_INC_REQ(POWER_INC_REQ),
    .POWER_DEC_REQ(POWER_DEC_REQ), .MAIN_EXCITER_B(MAIN_EXCITER_B),
    .AUTO_CHANGEOVER(AUTO_CHANGEOVER), .SCHEDULER_ON(SCHEDULER_ON),
    .LOCKOUT_ACTIVE(LOCKOUT_ACTIVE), .PRESET_REQ(PRESET_REQ), .PRESET_IDX(PRESET_IDX));

  initial
  begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  always @(posedge REF_CLK)
  begin
    if (!RST && (RF_ON_REQ || RF_OFF_REQ || SYS_RESET_REQ || PRESET_REQ || POWER_INC_REQ
        || POWER_DEC_REQ))
      n_req++;
    if (!RST && SYS_RESET_REQ)
      n_rst++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string name);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1;
    check(name, RDATA, exp);
  endtask : rd

  task automatic line(input int ch, input logic v);
    @(posedge REF_CLK);
    cmd_valid <= 1'b1;
    cmd_ch <= ch[3:0];
    cmd_level <= v;
    @(posedge REF_CLK);
    cmd_valid <= 1'b0;
    repeat (6) @(posedge REF_CLK);
    #1;
  endtask : line

  task automatic cpulse(input int b);
    @(posedge REF_CLK);
    cons[b] <= 1'b1;
    @(posedge REF_CLK);
    cons <= 4'h0;
    repeat (3) @(posedge REF_CLK);
    #1;
  endtask : cpulse

  function automatic logic [15:0] cfgw(input logic [3:0] f, input logic [3:0] m,
    input logic [2:0] i);
    return {5'h00, i, m, f};
  endfunction : cfgw

  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    errors++;
    $display("Watchdog expired");
    print_verdict();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    errors = 0;
    tests_run = 0;
    n_req = 0;
    n_rst = 0;
    RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 5'h00;
    WDATA = 16'h0000;
    cons = 4'h0;
    cmd_valid = 1'b0;
    cmd_ch = 4'h0;
    cmd_level = 1'b0;
    repeat (20) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(5'h12, 16'h0000, "status");
    rd(5'h13, 16'h0001, "settings");
    rd(5'h00, 16'h0000, "cfg0");
    rd(5'h1F, 16'h0000, "unmapped");
    $display("test reset_values done");
    wr(5'h00, cfgw(rcic_pkg::FN_RF, rcic_pkg::MD_RISE_ON, 3'h0));
    wr(5'h01, cfgw(rcic_pkg::FN_LOCKOUT, rcic_pkg::MD_RISE_ON, 3'h2));
    wr(5'h10, 16'h0001);
    line(0, 1'b1);
    line(1, 1'b1);
    check("rf_local", {15'h0000, RF_ON}, 16'h0000);
    check("lockout", {8'h00, LOCKOUT_ACTIVE}, 16'h0004);
    line(0, 1'b0);
    line(1, 1'b0);
    wr(5'h02, cfgw(rcic_pkg::FN_RESET, rcic_pkg::MD_RISE_ON, 3'h0));
    rd(5'h02, 16'h0002, "pending");
    wr(5'h10, 16'h0002);
    rd(5'h02, 16'h0000, "cancel");
    $display("test local_and_cancel done");
    cpulse(0);
    check("remote", {15'h0000, REMOTE_MODE}, 16'h0001);
    snap = n_req;
    line(0, 1'b1);
    check("rf_on", {15'h0000, RF_ON}, 16'h0001);
    check("rf_req", 16'(n_req - snap), 16'h0001);
    cpulse(3);
    check("rf_off", {15'h0000, RF_ON}, 16'h0000);
    check("rf_off_req", 16'(n_req - snap), 16'h0002);
    line(0, 1'b0);
    $display("test rf_control done");
    wr(5'h00, 16'h0000);
    wr(5'h01, 16'h0000);
    s = 1'b0;
    for (int m = 0; m < 14; m++)
    begin
      if (m > 0)
        wr(5'(m + 1), 16'h0000);
      wr(5'(m + 2), cfgw(rcic_pkg::FN_SCHED, 4'(m), 3'h0));
      wr(5'h10, 16'h0001);
      par = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
        lvl = !k[0];
        line(m + 2, lvl);
        case (m)
          0: if (lvl) s = 1'b1;
          1: if (!lvl) s = 1'b1;
          2: if (lvl) s = 1'b0;
          3: if (!lvl) s = 1'b0;
          4: if (!lvl) begin s = par; par = ~par; end
          5: if (lvl) begin s = ~par; par = ~par; end
          6, 12: s = lvl;
          7, 13: s = !lvl;
          8: if (lvl) s = 1'b1;
          default: s = s;
        endcase
        check("scheduler", {15'h0000, SCHEDULER_ON}, {15'h0000, s});
        rd(5'h11, lvl ? 16'h0001 << (m + 2) : 16'h0000, "level");
      end
    end
    $display("test trigger_modes done");
    wr(5'h0F, 16'h0000);
    wr(5'h10, 16'h0001);
    snap = n_req;
    line(0, 1'b1);
    line(0, 1'b0);
    check("unassigned", 16'(n_req - snap), 16'h0000);
    wr(5'h02, cfgw(rcic_pkg::FN_RESET, rcic_pkg::MD_RISE_ON, 3'h0));
    wr(5'h01, cfgw(rcic_pkg::FN_POWER_STEP, rcic_pkg::MD_HIGH_INC, 3'h0));
    wr(5'h05, cfgw(rcic_pkg::FN_POWER_STEP, rcic_pkg::MD_LOW_DEC, 3'h0));
    wr(5'h03, cfgw(rcic_pkg::FN_PRESET, rcic_pkg::MD_RISE_ON, 3'h5));
    wr(5'h04, cfgw(rcic_pkg::FN_AUTO_CO, rcic_pkg::MD_RISE_ON, 3'h0));
    wr(5'h06, cfgw(rcic_pkg::FN_MAIN_EXC, rcic_pkg::MD_RISE_FOLLOW, 3'h0));
    wr(5'h10, 16'h0001);
    repeat (6) @(posedge REF_CLK);
    #1;
    check("dec_held", {15'h0000, POWER_DEC_REQ}, 16'h0001);
    line(5, 1'b1);
    check("dec_off", {15'h0000, POWER_DEC_REQ}, 16'h0000);
    line(1, 1'b1);
    check("inc_held", {15'h0000, POWER_INC_REQ}, 16'h0001);
    line(1, 1'b0);
    check("inc_off", {15'h0000, POWER_INC_REQ}, 16'h0000);
    snap = n_rst;
    line(2, 1'b1);
    check("sys_reset", 16'(n_rst - snap), 16'h0001);
    line(3, 1'b1);
    check("preset", {13'h0000, PRESET_IDX}, 16'h0005);
    wr(5'h13, 16'h0000);
    line(4, 1'b1);
    check("auto_refused", {15'h0000, AUTO_CHANGEOVER}, 16'h0000);
    line(4, 1'b0);
    wr(5'h13, 16'h0001);
    line(4, 1'b1);
    line(6, 1'b1);
    check("auto_exc", {14'h0000, MAIN_EXCITER_B, AUTO_CHANGEOVER}, 16'h0003);
    rd(5'h12, {8'h04, 3'h0, s, 4'hD}, "status_all");
    cpulse(1);
    check("local", {15'h0000, REMOTE_MODE}, 16'h0000);
    $display("test functions done");
    print_verdict();
  end
endmodule : test_remote_control_input_conditioner
